// ===== eim_pkg.sv
// Purpose: shared constants of the receive interrupt mask and vector block
// Assumes: 10 MHz single clock, 8-bit host register port
// Notes: bit index of a source is word*8 + bit within its mask word
package eim_pkg;
    // register port shape
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam logic [4:0] IRQ_MASK_WORD_ZERO_OFF = 5'h1B;
    localparam logic [4:0] IRQ_MASK_WORD_ONE_OFF = 5'h1C;
    localparam logic [4:0] IRQ_MASK_WORD_TWO_OFF = 5'h1D;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    // word zero field positions, active low enables
    localparam int FRAME_SYNC_LOSS_MASK_N_BIT = 7;
    localparam int SLIP_MASK_N_BIT = 0;
    // word one field positions
    localparam int LOCAL_CRC_ERROR_EN_BIT = 6;
    localparam int REMOTE_ALARM_CRC_LONG_EN_BIT = 3;
    // word two field positions
    localparam int CRC_ALIGN_CHANGE_EN_BIT = 5;
    localparam int FAS_COUNTER_WRAP_EN_BIT = 4;
    // vector bit positions
    localparam int VEC_SYNC = 7;
    localparam int VEC_ERR = 5;
    localparam int VEC_WRAP = 4;
    localparam int VEC_ALIGN = 3;
    localparam int VEC_SLIP = 2;
    localparam int NSRC = 24;
    // sources feeding each vector bit, index 0 is vector bit 0
    localparam logic [23:0] GRP_SRC [0:7] = '{
        24'h000100, 24'h000000, 24'h080001, 24'h200000,
        24'hD50002, 24'h00FE04, 24'h020078, 24'h000080
    };
    // hold timing of the remote alarm with continuous crc errors
    localparam int CLK_HZ = 10_000_000;
    localparam int HOLD_MIN_MS = 10;
    localparam int HOLD_MAX_MS = 450;
    // least time rounds up, longest time rounds down
    localparam longint HOLD_MIN_CYC = (longint'(HOLD_MIN_MS) * CLK_HZ + 999) / 1000;
    localparam longint HOLD_MAX_CYC = (longint'(HOLD_MAX_MS) * CLK_HZ) / 1000;
    localparam int HOLD_CNT_W = 23;
endpackage

// ===== eim_edge.sv
// Purpose: turns a status level into a one-cycle event pulse
// Assumes: level is synchronous to mclk_i
// Notes: prev flop resets low, so a level already high flags once
`timescale 1ns/1ps
`default_nettype none
module eim_edge #(
    parameter bit BOTH = 1'b0 // one: either direction, zero: rise only
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic level_i,
    output logic pulse_o
);
    logic prev_r; // level one cycle ago

    // remember last level
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level_i;
        end
    end

    // registered pulse keeps the output glitch free
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pulse_o <= 1'b0;
        end else if (BOTH) begin
            pulse_o <= level_i ^ prev_r;
        end else begin
            pulse_o <= level_i & ~prev_r;
        end
    end
endmodule
`default_nettype wire

// ===== eim_hold_timer.sv
// Purpose: measures how long a condition level stays high
// Assumes: condition synchronous to mclk_i
// Notes: counter saturates at the window limit
`timescale 1ns/1ps
`default_nettype none
module eim_hold_timer #(
    parameter int CNT_W = 23,
    parameter int LONG_CYC = 100000, // held longer than this fires long
    parameter int WIN_CYC = 4500000 // ended below this fires window
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic cond_i,
    output logic long_o,
    output logic window_o
);
    logic [CNT_W-1:0] cnt_r; // cycles the condition has been high

    // count while high, restart on low, stop at the window limit
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= '0;
        end else if (!cond_i) begin
            cnt_r <= '0;
        end else if (cnt_r != CNT_W'(WIN_CYC)) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // long fires once, in the first cycle beyond the limit
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            long_o <= 1'b0;
        end else begin
            long_o <= cond_i && (cnt_r == CNT_W'(LONG_CYC));
        end
    end

    // window fires when the hold ends inside the range
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            window_o <= 1'b0;
        end else begin
            window_o <= !cond_i && (cnt_r > CNT_W'(LONG_CYC)) && (cnt_r < CNT_W'(WIN_CYC));
        end
    end
endmodule
`default_nettype wire

// ===== eim_irq_masks.sv
// Purpose: three interrupt mask words, pending vector and request pin
// Assumes: host port and event inputs synchronous to mclk_i
// Notes: page decode is done outside; this block sees its page only
`timescale 1ns/1ps
`default_nettype none
module eim_irq_masks
    import eim_pkg::*;
#(
    parameter int LONG_CYC = int'(HOLD_MIN_CYC), // 10 ms hold
    parameter int WIN_CYC = int'(HOLD_MAX_CYC) // 450 ms limit
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    // host register port
    input wire logic bus_cs_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic [ADDR_W-1:0] bus_addr_i,
    input wire logic [DATA_W-1:0] bus_wdata_i,
    output logic [DATA_W-1:0] bus_rdata_o,
    // control bits held in the neighbouring control word
    input wire logic interrupt_acknowledge_toggle_i,
    input wire logic interrupt_suspend_i,
    // word zero sources
    input wire logic sync_loss_i,
    input wire logic remote_alarm_i,
    input wire logic alarm_signal_i,
    input wire logic slot16_alarm_i,
    input wire logic signal_loss_i,
    input wire logic fas_error_i,
    input wire logic bpv_wrap_i,
    input wire logic slip_i,
    // word one sources
    input wire logic remote_crc_error_i,
    input wire logic local_crc_error_i,
    input wire logic double_fas_error_i,
    input wire logic bipolar_violation_i,
    input wire logic remote_alarm_crc_cond_i,
    input wire logic pattern_bit_error_i,
    input wire logic signalling_change_i,
    // word two sources
    input wire logic ebit_counter_wrap_i,
    input wire logic crc_counter_wrap_i,
    input wire logic crc_alignment_status_i,
    input wire logic fas_counter_wrap_i,
    input wire logic jitter_fifo_margin_i,
    input wire logic biterr_counter_wrap_i,
    input wire logic aux_pattern_status_i,
    input wire logic multiframe_counter_wrap_i,
    // request pin and vector
    output logic irq_n_o,
    output logic irq_oe_n_o,
    output logic [7:0] irq_vector_o
);
    // mask word registers
    logic [7:0] mask0_r; // word zero, one masks
    logic [7:0] mask1_r; // word one, one unmasks
    logic [7:0] mask2_r; // word two, one unmasks
    logic [7:0] vec_r; // pending group bits
    logic [7:0] vec_nxt; // next pending value
    logic [7:0] set_vec; // groups hit this cycle
    logic irq_n_r; // request pin level
    logic oe_n_r; // request pin enable, low drives
    logic ack_prev_r; // acknowledge bit one cycle ago
    logic ack_edge; // acknowledge toggled
    logic [NSRC-1:0] events; // all sources, word-major
    logic [NSRC-1:0] unmask; // common-polarity enables
    logic [NSRC-1:0] hits; // gated sources
    logic set_any; // any group hit
    logic crc_alignment_status_evt; // crc alignment changed
    logic aux_evt; // aux pattern rose
    logic jit_evt; // jitter margin reached
    logic long_evt; // alarm hold passed 10 ms
    logic win_evt; // alarm hold ended inside window
    logic wr_stb; // host write strobe
    logic rd_stb; // host read strobe

    // maps an address to a mask word index, 3 means unmapped
    function automatic logic [1:0] word_sel(input logic [ADDR_W-1:0] a);
        logic [1:0] s;
        s = 2'h3;
        case (a)
            IRQ_MASK_WORD_ZERO_OFF: s = 2'h0;
            IRQ_MASK_WORD_ONE_OFF: s = 2'h1;
            IRQ_MASK_WORD_TWO_OFF: s = 2'h2;
            default: s = 2'h3;
        endcase
        return s;
    endfunction

    assign wr_stb = bus_cs_i && bus_wr_i;
    assign rd_stb = bus_cs_i && bus_rd_i;

    // mask word zero write
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask0_r <= MASK_RST;
        end else if (wr_stb && word_sel(bus_addr_i) == 2'h0) begin
            mask0_r <= bus_wdata_i;
        end
    end

    // mask word one write
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask1_r <= MASK_RST;
        end else if (wr_stb && word_sel(bus_addr_i) == 2'h1) begin
            mask1_r <= bus_wdata_i;
        end
    end

    // mask word two write
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask2_r <= MASK_RST;
        end else if (wr_stb && word_sel(bus_addr_i) == 2'h2) begin
            mask2_r <= bus_wdata_i;
        end
    end

    // read data, registered, holds between reads
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_rdata_o <= RDATA_UNMAPPED;
        end else if (rd_stb) begin
            case (word_sel(bus_addr_i))
                2'h0: bus_rdata_o <= mask0_r;
                2'h1: bus_rdata_o <= mask1_r;
                2'h2: bus_rdata_o <= mask2_r;
                default: bus_rdata_o <= RDATA_UNMAPPED;
            endcase
        end
    end

    // crc alignment status, either direction counts
    eim_edge #(
        .BOTH(1'b1)
    ) u_crc_alignment_status (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .level_i(crc_alignment_status_i),
        .pulse_o(crc_alignment_status_evt)
    );

    // aux pattern status, rise only
    eim_edge #(
        .BOTH(1'b0)
    ) u_aux (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .level_i(aux_pattern_status_i),
        .pulse_o(aux_evt)
    );

    // jitter fifo margin, only the approach counts, not its stay
    eim_edge #(
        .BOTH(1'b0)
    ) u_jit (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .level_i(jitter_fifo_margin_i),
        .pulse_o(jit_evt)
    );

    // remote alarm with continuous crc errors, hold timing
    eim_hold_timer #(
        .CNT_W(HOLD_CNT_W),
        .LONG_CYC(LONG_CYC),
        .WIN_CYC(WIN_CYC)
    ) u_hold (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .cond_i(remote_alarm_crc_cond_i),
        .long_o(long_evt),
        .window_o(win_evt)
    );

    // gather sources in mask bit order
    always_comb begin
        events[7] = sync_loss_i;
        events[6] = remote_alarm_i;
        events[5] = alarm_signal_i;
        events[4] = slot16_alarm_i;
        events[3] = signal_loss_i;
        events[2] = fas_error_i;
        events[1] = bpv_wrap_i;
        events[0] = slip_i;
        events[15] = remote_crc_error_i;
        events[14] = local_crc_error_i;
        events[13] = double_fas_error_i;
        events[12] = bipolar_violation_i;
        events[11] = long_evt;
        events[10] = win_evt;
        events[9] = pattern_bit_error_i;
        events[8] = signalling_change_i;
        events[23] = ebit_counter_wrap_i;
        events[22] = crc_counter_wrap_i;
        events[21] = crc_alignment_status_evt;
        events[20] = fas_counter_wrap_i;
        events[19] = jit_evt;
        events[18] = biterr_counter_wrap_i;
        events[17] = aux_evt;
        events[16] = multiframe_counter_wrap_i;
    end

    // word zero is active low, the others active high
    assign unmask = {mask2_r, mask1_r, ~mask0_r};
    // suspend hides every source
    assign hits = interrupt_suspend_i ? '0 : (events & unmask);

    // each vector bit ors its group of sources
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_grp
            assign set_vec[g] = |(hits & GRP_SRC[g]);
        end
    endgenerate

    assign set_any = |set_vec;
    assign ack_edge = interrupt_acknowledge_toggle_i ^ ack_prev_r;

    // acknowledge bit history, either transition acknowledges
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_prev_r <= 1'b0;
        end else begin
            ack_prev_r <= interrupt_acknowledge_toggle_i;
        end
    end

    // clear first, then new hits, so a hit beside an acknowledge survives
    always_comb begin
        vec_nxt = (ack_edge ? 8'h00 : vec_r) | set_vec;
    end

    // pending vector accumulates across sources
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            vec_r <= 8'h00;
        end else begin
            vec_r <= vec_nxt;
        end
    end

    // request low while anything pends, tracks the vector
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_n_r <= 1'b1;
        end else begin
            irq_n_r <= ~|vec_nxt;
        end
    end

    // pin released while suspended; pull-up outside gives the level
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            oe_n_r <= 1'b0;
        end else begin
            oe_n_r <= interrupt_suspend_i;
        end
    end

    assign irq_n_o = irq_n_r;
    assign irq_oe_n_o = oe_n_r;
    assign irq_vector_o = vec_r;

    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    // a source seen, kept enabled, then the next cycle
    sequence s_crc_alignment_status_seen;
        $changed(crc_alignment_status_i) && mask2_r[CRC_ALIGN_CHANGE_EN_BIT] && !interrupt_suspend_i
        ##1 mask2_r[CRC_ALIGN_CHANGE_EN_BIT] && !interrupt_suspend_i;
    endsequence

    sequence s_long_seen;
        long_evt && mask1_r[REMOTE_ALARM_CRC_LONG_EN_BIT] && !interrupt_suspend_i;
    endsequence

    a_word0_polarity: assert property (
        (vec_r == 8'h00 && mask0_r == 8'hFF && mask1_r == 8'h00 && mask2_r == 8'h00)
        |=> (vec_r == 8'h00) && irq_n_o
    ) else $error("masked word zero source still set the vector");

    a_sync_loss_irq: assert property (
        (sync_loss_i && !mask0_r[FRAME_SYNC_LOSS_MASK_N_BIT] && !interrupt_suspend_i)
        |=> vec_r[VEC_SYNC] && !irq_n_o
    ) else $error("unmasked sync loss gave no interrupt");

    a_slip_vector: assert property (
        (slip_i && !mask0_r[SLIP_MASK_N_BIT] && !interrupt_suspend_i)
        |=> vec_r[VEC_SLIP]
    ) else $error("unmasked slip gave no vector bit");

    a_local_crc_vec: assert property (
        (local_crc_error_i && mask1_r[LOCAL_CRC_ERROR_EN_BIT] && !interrupt_suspend_i)
        |=> vec_r[VEC_ERR]
    ) else $error("unmasked crc error gave no vector bit");

    a_long_hold_vec: assert property (
        s_long_seen |=> vec_r[VEC_ERR] && !irq_n_o
    ) else $error("long alarm hold gave no interrupt");

    a_counter_wrap_vec: assert property (
        (fas_counter_wrap_i && mask2_r[FAS_COUNTER_WRAP_EN_BIT] && !interrupt_suspend_i)
        |=> vec_r[VEC_WRAP]
    ) else $error("unmasked counter wrap gave no vector bit");

    a_crc_alignment_status_change_vec: assert property (
        s_crc_alignment_status_seen |=> vec_r[VEC_ALIGN]
    ) else $error("alignment change gave no vector bit");

    a_ack_clears_all: assert property (
        (ack_edge && !set_any) |=> (vec_r == 8'h00) && irq_n_o
    ) else $error("acknowledge did not clear the request");

    a_suspend_float: assert property (
        interrupt_suspend_i |=> irq_oe_n_o
    ) else $error("request pin driven while suspended");

    a_suspend_ignores: assert property (
        (interrupt_suspend_i && !ack_edge) |=> vec_r == $past(vec_r)
    ) else $error("source accepted while suspended");

    a_pending_holds: assert property (
        (vec_r != 8'h00 && !ack_edge) |=> ((vec_r & $past(vec_r)) == $past(vec_r)) && !irq_n_o
    ) else $error("pending bit dropped without acknowledge");
endmodule
`default_nettype wire

// ===== eim_host_model.sv
// Purpose: host processor model on the mask register port
// Assumes: strobes change at the falling edge of mclk_i
// Notes: released address and data show their inverse, never the last value
`timescale 1ns/1ps
`default_nettype none
module eim_host_model (
    input wire logic mclk_i,
    output logic bus_cs_o,
    output logic bus_wr_o,
    output logic bus_rd_o,
    output logic [4:0] bus_addr_o,
    output logic [7:0] bus_wdata_o,
    output logic ack_tgl_o,
    output logic susp_o
);
    // idle bus at time zero
    initial begin
        bus_cs_o = 1'b0;
        bus_wr_o = 1'b0;
        bus_rd_o = 1'b0;
        bus_addr_o = 5'h00;
        bus_wdata_o = 8'h00;
        ack_tgl_o = 1'b0;
        susp_o = 1'b0;
    end
    // one access, taken at the rising edge between two falling edges
    task automatic access(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        bus_cs_o = 1'b1;
        bus_wr_o = w;
        bus_rd_o = ~w;
        bus_addr_o = a;
        bus_wdata_o = d;
        @(negedge mclk_i);
        bus_cs_o = 1'b0;
        bus_wr_o = 1'b0;
        bus_rd_o = 1'b0;
        bus_addr_o = ~a;
        bus_wdata_o = ~d;
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        access(1'b1, a, d);
    endtask
    task automatic rd_reg(input logic [4:0] a);
        access(1'b0, a, 8'h00);
    endtask
    // either direction acknowledges; caller picks the falling edge
    task automatic ack();
        ack_tgl_o = ~ack_tgl_o;
    endtask
    task automatic suspend(input logic v);
        susp_o = v;
    endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench of the interrupt mask and vector block
// Assumes: hold limits shortened to 20 and 60 cycles
// Notes: driver notes expected values, observer compares in order
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import eim_pkg::*;
    localparam int LONG_T = 20; // shortened long hold
    localparam int WIN_T = 60; // shortened window limit
    logic mclk_i, resetn_i = 1'b0;
    logic bus_cs, bus_wr, bus_rd, ack_tgl, susp, irq_n, irq_oe_n;
    logic [ADDR_W-1:0] bus_addr;
    logic [DATA_W-1:0] bus_wdata, bus_rdata;
    logic [23:0] src = 24'h000000; // source levels, index word*8+bit
    logic hold_cond; // long and window sources share one condition pin
    assign hold_cond = src[11] | src[10];
    logic [7:0] vec, last_vec = 8'h00;
    logic [7:0] exp_rd[$]; // expected read data
    logic [7:0] exp_vec[$]; // expected vector values in order
    logic rd_p1 = 1'b0, rd_p2 = 1'b0; // read seen, one and two edges ago
    int miscompares = 0, comparisons = 0;
    // vector bit of each source index
    byte vb [24] = '{2, 4, 5, 6, 6, 6, 6, 7, 0, 5, 5, 5, 5, 5, 5, 5, 4, 6, 4, 2, 4, 3, 4, 4};

    eim_host_model eim_host_model_i (.mclk_i(mclk_i), .bus_cs_o(bus_cs), .bus_wr_o(bus_wr), .bus_rd_o(bus_rd),
        .bus_addr_o(bus_addr), .bus_wdata_o(bus_wdata), .ack_tgl_o(ack_tgl), .susp_o(susp));
    eim_irq_masks #(.LONG_CYC(LONG_T), .WIN_CYC(WIN_T)) eim_irq_masks_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .bus_cs_i(bus_cs), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_addr_i(bus_addr), .bus_wdata_i(bus_wdata),
        .bus_rdata_o(bus_rdata), .interrupt_acknowledge_toggle_i(ack_tgl), .interrupt_suspend_i(susp),
        .sync_loss_i(src[7]), .remote_alarm_i(src[6]), .alarm_signal_i(src[5]), .slot16_alarm_i(src[4]),
        .signal_loss_i(src[3]), .fas_error_i(src[2]), .bpv_wrap_i(src[1]), .slip_i(src[0]),
        .remote_crc_error_i(src[15]), .local_crc_error_i(src[14]), .double_fas_error_i(src[13]),
        .bipolar_violation_i(src[12]), .remote_alarm_crc_cond_i(hold_cond),
        .pattern_bit_error_i(src[9]), .signalling_change_i(src[8]), .ebit_counter_wrap_i(src[23]),
        .crc_counter_wrap_i(src[22]), .crc_alignment_status_i(src[21]), .fas_counter_wrap_i(src[20]),
        .jitter_fifo_margin_i(src[19]), .biterr_counter_wrap_i(src[18]), .aux_pattern_status_i(src[17]),
        .multiframe_counter_wrap_i(src[16]), .irq_n_o(irq_n), .irq_oe_n_o(irq_oe_n), .irq_vector_o(vec));

    // free-running 10 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // observer: read data one edge late so either latency reading holds
    always @(posedge mclk_i) begin
        rd_p1 <= bus_cs & bus_rd;
        rd_p2 <= rd_p1;
    end
    always @(negedge mclk_i) begin
        if (rd_p2) begin
            check(bus_rdata, exp_rd.size() ? exp_rd.pop_front() : 8'hXX);
        end
        // every vector change must be the oldest note
        if (vec !== last_vec) begin
            check(vec, exp_vec.size() ? exp_vec.pop_front() : 8'hXX);
            last_vec = vec;
        end
        check({7'h00, irq_n}, {7'h00, ~|vec});
    end
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] want);
        exp_rd.push_back(want);
        eim_host_model_i.rd_reg(a);
        repeat (2) @(negedge mclk_i);
    endtask
    task automatic set_masks(input logic [7:0] m0, input logic [7:0] m1, input logic [7:0] m2);
        eim_host_model_i.wr_reg(IRQ_MASK_WORD_ZERO_OFF, m0);
        eim_host_model_i.wr_reg(IRQ_MASK_WORD_ONE_OFF, m1);
        eim_host_model_i.wr_reg(IRQ_MASK_WORD_TWO_OFF, m2);
    endtask
    // raise one source for w cycles, then let the answer settle
    task automatic fire(input int i, input int w);
        @(negedge mclk_i);
        src[i] = 1'b1;
        repeat (w) @(negedge mclk_i);
        src[i] = 1'b0;
        repeat (5) @(negedge mclk_i);
    endtask
    // watchdog, about ten times the expected run
    initial begin
        #1_000_000;
        miscompares++;
        close_out();
    end
    initial begin
        int i, w;
        logic [23:0] m;
        logic [7:0] acc, nv, d;
        logic [4:0] a;
        void'($urandom(32'hEA21));
        repeat (3) @(negedge mclk_i);
        resetn_i = 1'b1;
        // unmapped writes first, then reset values of the three mask words
        eim_host_model_i.wr_reg(5'h1A, 8'h5A);
        eim_host_model_i.wr_reg(5'h1E, 8'hA5);
        for (int k = 0; k < 3; k++) rd_chk(IRQ_MASK_WORD_ZERO_OFF + 5'(k), MASK_RST);
        // random write and readback
        repeat (8) begin
            a = IRQ_MASK_WORD_ZERO_OFF + 5'($urandom_range(2));
            d = 8'($urandom);
            eim_host_model_i.wr_reg(a, d);
            rd_chk(a, d);
        end
        // unmapped reads must echo neither a mask nor the last read value
        set_masks(8'h5A, 8'hC3, 8'h3C);
        rd_chk(IRQ_MASK_WORD_TWO_OFF, 8'h3C);
        rd_chk(5'h1A, RDATA_UNMAPPED);
        rd_chk(5'h1E, RDATA_UNMAPPED);
        // each source masked, then alone unmasked, then acknowledged
        for (i = 0; i < 24; i++) begin
            w = (i == 10 || i == 11) ? 30 : 1;
            set_masks(8'hFF, 8'h00, 8'h00);
            fire(i, w);
            m = 24'h000001 << i;
            set_masks(~m[7:0], m[15:8], m[23:16]);
            exp_vec.push_back(8'h01 << vb[i]);
            fire(i, w);
            exp_vec.push_back(8'h00);
            eim_host_model_i.ack();
            repeat (3) @(negedge mclk_i);
        end
        // suspend floats the pin and drops sources
        set_masks(8'h7E, 8'h00, 8'h00);
        eim_host_model_i.suspend(1'b1);
        repeat (3) @(negedge mclk_i);
        check({7'h00, irq_oe_n}, 8'h01);
        fire(7, 1);
        eim_host_model_i.suspend(1'b0);
        repeat (3) @(negedge mclk_i);
        check({7'h00, irq_oe_n}, 8'h00);
        exp_vec.push_back(8'h80);
        fire(7, 1);
        // slip in the acknowledge cycle survives the clear
        exp_vec.push_back(8'h04);
        src[0] = 1'b1;
        eim_host_model_i.ack();
        @(negedge mclk_i);
        src[0] = 1'b0;
        repeat (4) @(negedge mclk_i);
        // random sources accumulate with everything unmasked
        set_masks(8'h00, 8'hFF, 8'hFF);
        acc = 8'h04;
        repeat (12) begin
            i = $urandom_range(23);
            i = (i == 10 || i == 11) ? 0 : i;
            nv = acc | (8'h01 << vb[i]);
            if (nv !== acc) exp_vec.push_back(nv);
            acc = nv;
            fire(i, 1);
        end
        exp_vec.push_back(8'h00);
        eim_host_model_i.ack();
        repeat (4) @(negedge mclk_i);
        check(8'(exp_vec.size() + exp_rd.size()), 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
